/* File: lrovr_params.svh */
// Constants for the lane route override register bank.
// Included by the design, the host model and the bench; definitions only.
`ifndef LROVR_PARAMS_SVH
`define LROVR_PARAMS_SVH

// Register offsets on the serial management port
`define LROVR_ADDR_RSVD_4C      8'h4C
`define LROVR_ADDR_CHIP_ID      8'h51
`define LROVR_ADDR_RSVD_56      8'h56
`define LROVR_ADDR_RSVD_57      8'h57
`define LROVR_ADDR_RSVD_58      8'h58
`define LROVR_ADDR_RSVD_59      8'h59
`define LROVR_ADDR_RSVD_5A      8'h5A
`define LROVR_ADDR_RSVD_5B      8'h5B
`define LROVR_ADDR_TAKEOVER     8'h5E
`define LROVR_ADDR_ROUTE_CTRL   8'h5F

// Reset values
`define LROVR_RST_RSVD_4C       8'h00
`define LROVR_RST_RSVD_56       8'h10
`define LROVR_RST_RSVD_57       8'h64
`define LROVR_RST_RSVD_58       8'h21
`define LROVR_RST_RSVD_59       8'h00
`define LROVR_RST_RSVD_5A       8'h54
`define LROVR_RST_RSVD_5B       8'h54
`define LROVR_RST_TAKEOVER      8'h00
`define LROVR_RST_ROUTE_CTRL    8'h00

// Field positions
`define LROVR_TK_LANE1_BIT      2
`define LROVR_TK_LANE0_BIT      1
`define LROVR_TK_ACT_BIT        0
`define LROVR_TK_MASK           8'h07
`define LROVR_CTRL_MASK         8'hFC
`define LROVR_LANE1_HI          7
`define LROVR_LANE1_LO          6
`define LROVR_LANE0_HI          5
`define LROVR_LANE0_LO          4
`define LROVR_ACT_HI            3
`define LROVR_ACT_LO            2

// Identification fields (arbitrary neutral values)
`define LROVR_ID_REVISION       3'h1
`define LROVR_ID_PART           5'h15

// Serial port slave address (arbitrary default)
`define LROVR_SLAVE_ADDR        7'h58

`endif

/* File: lrovr_pkg.sv */
// Types for the lane route override register bank.
// Assumes lrovr_params.svh is on the include path.
package lrovr_pkg;
	// Serial port protocol states
	typedef enum logic [2:0] {
		LROVR_IDLE,
		LROVR_DEV,
		LROVR_PTR,
		LROVR_WR,
		LROVR_ACK,
		LROVR_RD,
		LROVR_RACK
	} lrovr_state_t;

	// Port activation modes
	typedef enum logic [1:0] {
		LROVR_ACT_NORMAL = 2'h0,
		LROVR_ACT_RSVD   = 2'h1,
		LROVR_ACT_AUTO   = 2'h2,
		LROVR_ACT_BCAST  = 2'h3
	} lrovr_act_t;
endpackage

/* File: lrovr_regs.sv */
// Register bank and route decode of a dual-lane 2:1 mux / 1:2 switch.
// Assumes serial port pins and straps are synchronous to clk_i;
// the open-drain data line is resolved outside from sda_oe_o.
`timescale 1ns/1ps
`include "lrovr_params.svh"

// Notes on behaviour
// [RL1] Takeover bit 2 makes lane 1 follow the control field instead of its strap pin.
// [RL2] Takeover bit 1 makes lane 0 follow the control field instead of its strap pin.
// [RL3] Takeover bit 0 makes the activation mode follow the control field, not the pin.
// [RL4] The takeover register resets to zero so the straps govern until software acts.
// [RL5] Lane 1 code in bits 7:6: high bit picks input A over B, low bit output A over B.
// [RL6] Lane 0 code in bits 5:4 uses the same mapping as lane 1.
// [RL7] Activation 00 is normal: no broadcast, routed ports, input terminated; 01 reserved.
// [RL8] Activation 10 is automatic: receiver detection gates the routed output ports, no broadcast.
// [RL9] Activation 11 broadcasts to both outputs of each lane with the input terminated.
// [RL10] The identification register is read only with revision over part code.
// [RL11] Reserved registers keep their values and never alter routing.
module lrovr_regs (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic [1:0] lane0_route_pin_i,
	input  wire logic [1:0] lane1_route_pin_i,
	input  wire logic [1:0] activation_pin_i,
	input  wire logic [3:0] rx_detected_i,
	output logic            lane0_input_port_a_o,
	output logic            lane0_input_port_b_o,
	output logic            lane1_input_port_a_o,
	output logic            lane1_input_port_b_o,
	output logic            lane0_output_port_a_o,
	output logic            lane0_output_port_b_o,
	output logic            lane1_output_port_a_o,
	output logic            lane1_output_port_b_o,
	output logic            broadcast_both_outputs_o,
	output lrovr_pkg::lrovr_act_t active_mode_o
);
	import lrovr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Serial port edge detection
	logic scl_reg, sda_reg;
	logic scl_rise, scl_fall, start_seen, stop_seen;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_i;
			sda_reg <= sda_i;
		end
	end

	assign scl_rise   = scl_i & ~scl_reg;
	assign scl_fall   = ~scl_i & scl_reg;
	assign start_seen = scl_i & scl_reg & sda_reg & ~sda_i;
	assign stop_seen  = scl_i & scl_reg & ~sda_reg & sda_i;

	////////////////////////////////////////////////////////////////////////
	// Protocol engine state
	lrovr_state_t state_reg, state_next, after_reg, after_next;
	logic [7:0]   shift_reg, shift_next, ptr_reg, ptr_next;
	logic [3:0]   bits_reg, bits_next;
	logic         drive_reg, drive_next, acked_reg, acked_next;
	logic         wr_en;
	logic [7:0]   rd_data;

	// Next state of the byte engine; start and stop win over bit traffic
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		shift_next = shift_reg;
		ptr_next   = ptr_reg;
		bits_next  = bits_reg;
		drive_next = drive_reg;
		acked_next = acked_reg;
		wr_en      = 1'b0;
		if (start_seen) begin
			state_next = LROVR_DEV;
			bits_next  = 4'h0;
			drive_next = 1'b0;
		end else if (stop_seen) begin
			state_next = LROVR_IDLE;
			drive_next = 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				LROVR_DEV, LROVR_PTR, LROVR_WR: begin
					shift_next = {shift_reg[6:0], sda_i};
					bits_next  = bits_reg + 4'h1;
				end
				LROVR_RD: bits_next = bits_reg + 4'h1;
				LROVR_RACK: acked_next = ~sda_i; // Low means master wants more
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				LROVR_DEV: if (bits_reg == 4'h8) begin
					if (shift_reg[7:1] == `LROVR_SLAVE_ADDR) begin
						state_next = LROVR_ACK;
						drive_next = 1'b1;
						after_next = shift_reg[0] ? LROVR_RD : LROVR_PTR;
					end else begin
						state_next = LROVR_IDLE; // Not our address
					end
				end
				LROVR_PTR: if (bits_reg == 4'h8) begin
					ptr_next   = shift_reg;
					state_next = LROVR_ACK;
					drive_next = 1'b1;
					after_next = LROVR_WR;
				end
				LROVR_WR: if (bits_reg == 4'h8) begin
					wr_en      = 1'b1;
					ptr_next   = ptr_reg + 8'h01;
					state_next = LROVR_ACK;
					drive_next = 1'b1;
				end
				LROVR_ACK: begin
					bits_next  = 4'h0;
					state_next = after_reg;
					drive_next = 1'b0;
					if (after_reg == LROVR_RD) begin
						shift_next = rd_data;
						ptr_next   = ptr_reg + 8'h01;
						drive_next = ~rd_data[7];
					end
				end
				LROVR_RD: begin
					if (bits_reg == 4'h8) begin
						state_next = LROVR_RACK;
						drive_next = 1'b0;
					end else begin
						shift_next = {shift_reg[6:0], 1'b0};
						drive_next = ~shift_reg[6];
					end
				end
				LROVR_RACK: begin
					bits_next = 4'h0;
					if (acked_reg) begin
						state_next = LROVR_RD;
						shift_next = rd_data;
						ptr_next   = ptr_reg + 8'h01;
						drive_next = ~rd_data[7];
					end else begin
						state_next = LROVR_IDLE; // Nack ends the read
					end
				end
				default: ;
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= LROVR_IDLE;
			after_reg <= LROVR_IDLE;
			shift_reg <= 8'h00;
			ptr_reg   <= 8'h00;
			bits_reg  <= 4'h0;
			drive_reg <= 1'b0;
			acked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			shift_reg <= shift_next;
			ptr_reg   <= ptr_next;
			bits_reg  <= bits_next;
			drive_reg <= drive_next;
			acked_reg <= acked_next;
		end
	end

	// Open drain: only ever pull low
	assign sda_o    = 1'b0;
	assign sda_oe_o = drive_reg;

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] rsvd_reg [0:6];
	logic [7:0] rsvd_next [0:6];
	logic [7:0] takeover_reg, takeover_next, ctrl_reg, ctrl_next;
	logic [7:0] rsvd_addr [0:6];

	assign rsvd_addr[0] = `LROVR_ADDR_RSVD_4C;
	assign rsvd_addr[1] = `LROVR_ADDR_RSVD_56;
	assign rsvd_addr[2] = `LROVR_ADDR_RSVD_57;
	assign rsvd_addr[3] = `LROVR_ADDR_RSVD_58;
	assign rsvd_addr[4] = `LROVR_ADDR_RSVD_59;
	assign rsvd_addr[5] = `LROVR_ADDR_RSVD_5A;
	assign rsvd_addr[6] = `LROVR_ADDR_RSVD_5B;
	// Write decode and read mux; identification ignores writes
	always_comb begin
		takeover_next = takeover_reg;
		ctrl_next     = ctrl_reg;
		rd_data       = 8'h00; // Unlisted offsets read zero
		for (int i = 0; i < 7; i++) begin
			rsvd_next[i] = rsvd_reg[i];
			if (wr_en && ptr_reg == rsvd_addr[i])
				rsvd_next[i] = shift_reg; // RL11
			if (ptr_reg == rsvd_addr[i])
				rd_data = rsvd_reg[i];
		end
		if (wr_en && ptr_reg == `LROVR_ADDR_TAKEOVER)
			takeover_next = shift_reg & `LROVR_TK_MASK;
		if (wr_en && ptr_reg == `LROVR_ADDR_ROUTE_CTRL)
			ctrl_next = shift_reg & `LROVR_CTRL_MASK;
		case (ptr_reg)
			`LROVR_ADDR_CHIP_ID:    rd_data = {`LROVR_ID_REVISION, `LROVR_ID_PART}; // RL10
			`LROVR_ADDR_TAKEOVER:   rd_data = takeover_reg;
			`LROVR_ADDR_ROUTE_CTRL: rd_data = ctrl_reg;
			default: ;
		endcase
	end

	// Register file flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			takeover_reg <= `LROVR_RST_TAKEOVER; // RL4
			ctrl_reg     <= `LROVR_RST_ROUTE_CTRL;
			rsvd_reg[0]  <= `LROVR_RST_RSVD_4C;
			rsvd_reg[1]  <= `LROVR_RST_RSVD_56;
			rsvd_reg[2]  <= `LROVR_RST_RSVD_57;
			rsvd_reg[3]  <= `LROVR_RST_RSVD_58;
			rsvd_reg[4]  <= `LROVR_RST_RSVD_59;
			rsvd_reg[5]  <= `LROVR_RST_RSVD_5A;
			rsvd_reg[6]  <= `LROVR_RST_RSVD_5B;
		end else begin
			takeover_reg <= takeover_next;
			ctrl_reg     <= ctrl_next;
			for (int i = 0; i < 7; i++)
				rsvd_reg[i] <= rsvd_next[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Route decode: pin or register source, then per-lane enables
	logic [1:0] lane0_route_choice, lane1_route_choice;
	lrovr_act_t mode;
	logic [9:0] route_next, route_reg;
	logic       bcast_next;

	assign lane1_route_choice = takeover_reg[`LROVR_TK_LANE1_BIT] ?
		ctrl_reg[`LROVR_LANE1_HI:`LROVR_LANE1_LO] : lane1_route_pin_i; // RL1
	assign lane0_route_choice = takeover_reg[`LROVR_TK_LANE0_BIT] ?
		ctrl_reg[`LROVR_LANE0_HI:`LROVR_LANE0_LO] : lane0_route_pin_i; // RL2
	assign mode = lrovr_act_t'(takeover_reg[`LROVR_TK_ACT_BIT] ?
		ctrl_reg[`LROVR_ACT_HI:`LROVR_ACT_LO] : activation_pin_i); // RL3

	// Code bit 1 picks input A, bit 0 picks output A
	// Detect bits line up with the output enables, lane 0 A in bit 3
	// Reserved activation code falls back to normal so a stray code never blanks a lane
	always_comb begin
		bcast_next = (mode == LROVR_ACT_BCAST); // RL9
		route_next = {2'(mode),
			lane0_route_choice[1], ~lane0_route_choice[1],   // RL6
			lane1_route_choice[1], ~lane1_route_choice[1],   // RL5
			lane0_route_choice[0], ~lane0_route_choice[0],
			lane1_route_choice[0], ~lane1_route_choice[0]};
		case (mode)
			LROVR_ACT_BCAST: route_next[3:0] = 4'hF; // RL9
			LROVR_ACT_AUTO:  route_next[3:0] = route_next[3:0] & rx_detected_i; // RL8
			default: ; // RL7
		endcase
	end

	// Outputs come from flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			route_reg                <= 10'h000;
			broadcast_both_outputs_o <= 1'b0;
		end else begin
			route_reg                <= route_next;
			broadcast_both_outputs_o <= bcast_next;
		end
	end

	assign active_mode_o         = lrovr_act_t'(route_reg[9:8]);
	assign lane0_input_port_a_o  = route_reg[7];
	assign lane0_input_port_b_o  = route_reg[6];
	assign lane1_input_port_a_o  = route_reg[5];
	assign lane1_input_port_b_o  = route_reg[4];
	assign lane0_output_port_a_o = route_reg[3];
	assign lane0_output_port_b_o = route_reg[2];
	assign lane1_output_port_a_o = route_reg[1];
	assign lane1_output_port_b_o = route_reg[0];
endmodule // lrovr_regs

/* File: lrovr_regs_monitor.sv */
// Port-level checker for the lane route register bank.
// Assumes one clock domain; bound onto lrovr_regs below.
`timescale 1ns/1ps
module lrovr_regs_monitor (
	input wire logic          clk_i,
	input wire logic          rst_n_i,
	input wire logic          scl_i,
	input wire logic [1:0]    lane0_route_pin_i,
	input wire logic [1:0]    lane1_route_pin_i,
	input wire logic [1:0]    activation_pin_i,
	input wire logic [3:0]    rx_detected_i,
	input wire logic          lane0_input_port_a_o,
	input wire logic          lane0_input_port_b_o,
	input wire logic          lane1_input_port_a_o,
	input wire logic          lane1_input_port_b_o,
	input wire logic          lane0_output_port_a_o,
	input wire logic          lane0_output_port_b_o,
	input wire logic          lane1_output_port_a_o,
	input wire logic          lane1_output_port_b_o,
	input wire logic          broadcast_both_outputs_o,
	input lrovr_pkg::lrovr_act_t active_mode_o
);
	import lrovr_pkg::*;
	logic [1:0] cnt_reg, cnt_next;
	logic       pin_only_reg, pin_only_next;
	wire  [3:0] outs = {lane0_output_port_a_o, lane0_output_port_b_o,
		lane1_output_port_a_o, lane1_output_port_b_o};
	// Settle count; outputs are registered, so skip the first edges
	always_comb begin
		cnt_next = (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
		pin_only_next = pin_only_reg & scl_i;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 2'h0;
			pin_only_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			pin_only_reg <= pin_only_next;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Serial clock idle and straps quiet; long enough for a late write
	sequence s_still;
		(scl_i && $stable(lane0_route_pin_i) && $stable(lane1_route_pin_i)
			&& $stable(activation_pin_i) && $stable(rx_detected_i)) [*5];
	endsequence
	a_lane0_onehot: assert property (
		cnt_reg[1] |-> lane0_input_port_a_o != lane0_input_port_b_o)
		else $error("lane 0 input select not one-hot");
	a_lane1_onehot: assert property (
		cnt_reg[1] |-> lane1_input_port_a_o != lane1_input_port_b_o)
		else $error("lane 1 input select not one-hot");
	a_bcast_flag: assert property (
		cnt_reg[1] |-> broadcast_both_outputs_o == (active_mode_o == LROVR_ACT_BCAST))
		else $error("broadcast flag disagrees with mode");
	a_bcast_outs: assert property (broadcast_both_outputs_o |-> outs == 4'hF)
		else $error("broadcast without all outputs on");
	// Normal and reserved codes must select exactly one output per lane
	a_normal_outs: assert property (
		cnt_reg[1] && (active_mode_o == LROVR_ACT_NORMAL || active_mode_o == LROVR_ACT_RSVD)
		|-> outs[3] != outs[2] && outs[1] != outs[0])
		else $error("normal or reserved mode output select not one-hot");
	a_auto_gate: assert property (
		cnt_reg[1] && active_mode_o == LROVR_ACT_AUTO
		|-> (outs & ~$past(rx_detected_i)) == 4'h0)
		else $error("auto mode drives undetected output");
	a_pins_govern: assert property (
		pin_only_reg && cnt_reg[1] |->
			{lane0_input_port_a_o, lane1_input_port_a_o, broadcast_both_outputs_o} ==
			{$past(lane0_route_pin_i[1]), $past(lane1_route_pin_i[1]),
			$past(activation_pin_i) == 2'h3})
		else $error("straps not followed after reset");
	a_route_still: assert property (
		s_still ##0 cnt_reg == 2'h3 |-> $stable(outs) && $stable(active_mode_o))
		else $error("routing moved with no cause");
endmodule // lrovr_regs_monitor
////////////////////////////////////////////////////////////
bind lrovr_regs lrovr_regs_monitor mon (.*);

/* File: lrovr_host.sv */
// Host model for the serial management port, open-drain data.
// Assumes the bench resolves the data wire; released line reads high.
`timescale 1ns/1ps
`include "lrovr_params.svh"
module lrovr_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic ack_ok;
	// Idle bus: both lines released
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		ack_ok = 1'b0;
	end
	// One phase lasts three clocks, changes just after an edge
	task automatic ph(input logic c, input logic d);
		repeat (3) @(posedge clk_i);
		#2;
		scl_o = c;
		sda_o = d;
	endtask
	task automatic sta();
		ph(1'b0, sda_o);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	task automatic sto();
		ph(1'b0, sda_o);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	// Nine bits MSB first; data only moves while the clock is low
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, sda_o);
			ph(1'b0, d[i]);
			ph(1'b1, d[i]);
			repeat (2) @(posedge clk_i);
			#1;
			q[i] = sda_i;
		end
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
		logic [8:0] q0, q1, q2;
		sta();
		xfer({dev, 2'b01}, q0);
		xfer({a, 1'b1}, q1);
		xfer({d, 1'b1}, q2);
		sto();
		ack_ok = !(q0[0] | q1[0] | q2[0]);
	endtask
	// Pointer write, repeated start, one byte read with a final refusal
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic [8:0] q0, q1, q2, q3;
		sta();
		xfer({`LROVR_SLAVE_ADDR, 2'b01}, q0);
		xfer({a, 1'b1}, q1);
		sta();
		xfer({`LROVR_SLAVE_ADDR, 2'b11}, q2);
		xfer(9'h1FF, q3);
		sto();
		v = q3[8:1];
		ack_ok = !(q0[0] | q1[0] | q2[0]);
	endtask
endmodule // lrovr_host

/* File: tb_lane_route_override_regs.sv */
// Self-checking bench for the lane route override register bank.
// Assumes lrovr_host drives the serial port; bench drives straps.
`timescale 1ns/1ps
`include "lrovr_params.svh"
module tb_lane_route_override_regs;
	import lrovr_pkg::*;
	typedef struct {logic [7:0] tk, ctrl; logic [1:0] p0, p1, pa; logic [3:0] rx;} lrovr_row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        scl, sda_h, sda_oe;
	logic [1:0]  p0 = 2'h0, p1 = 2'h0, pa = 2'h0;
	logic [3:0]  rx = 4'h0;
	logic [7:0]  v, cur_tk = 8'h00, cur_ctrl = 8'h00;
	wire  [10:0] outs;
	wire         sda_w = sda_oe ? 1'b0 : sda_h;
	int          miscompares = 0;
	int          num_checks = 0;
	lrovr_row_t  rows [11] = '{'{8'h00, 8'h00, 0, 3, 0, 0}, '{8'h00, 8'h00, 2, 1, 3, 0},
		'{8'h00, 8'h00, 1, 2, 2, 4'hA}, '{8'h07, 8'h1C, 2, 3, 0, 0}, '{8'h04, 8'hE0, 3, 0, 2, 4'h5},
		'{8'h02, 8'h98, 0, 1, 3, 0}, '{8'h01, 8'h98, 0, 3, 0, 4'h6}, '{8'h07, 8'h60, 1, 0, 3, 0},
		'{8'h00, 8'hFC, 2, 1, 0, 0}, '{8'h01, 8'h04, 1, 2, 0, 4'h3},
		'{8'h00, 8'h04, 3, 3, 1, 0}};
	logic [15:0] tbl [10] = '{16'h4C00, {8'h51, `LROVR_ID_REVISION, `LROVR_ID_PART}, 16'h5610,
		16'h5764, 16'h5821, 16'h5900, 16'h5A54, 16'h5B54, 16'h5E00, 16'h5F00};
	lrovr_regs uut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(),
		.sda_oe_o(sda_oe), .lane0_route_pin_i(p0), .lane1_route_pin_i(p1), .activation_pin_i(pa),
		.rx_detected_i(rx), .lane0_input_port_a_o(outs[10]), .lane0_input_port_b_o(outs[9]),
		.lane1_input_port_a_o(outs[8]), .lane1_input_port_b_o(outs[7]),
		.lane0_output_port_a_o(outs[6]), .lane0_output_port_b_o(outs[5]),
		.lane1_output_port_a_o(outs[4]), .lane1_output_port_b_o(outs[3]),
		.broadcast_both_outputs_o(outs[2]), .active_mode_o(outs[1:0]));
	lrovr_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
	always #20 clk = ~clk;
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	// Expected routing from the chosen codes; reserved mode routes as normal
	function automatic logic [10:0] model(lrovr_row_t r);
		logic [1:0] c0, c1, m;
		logic [3:0] o;
		c0 = r.tk[1] ? r.ctrl[5:4] : r.p0;
		c1 = r.tk[2] ? r.ctrl[7:6] : r.p1;
		m = r.tk[0] ? r.ctrl[3:2] : r.pa;
		o = {c0[0], !c0[0], c1[0], !c1[0]};
		if (m == 2'h2) o = o & r.rx;
		if (m == 2'h3) o = 4'hF;
		return {c0[1], !c0[1], c1[1], !c1[1], o, m == 2'h3, m};
	endfunction
	task automatic settle(lrovr_row_t r);
		@(posedge clk) #2;
		{p0, p1, pa, rx} = {r.p0, r.p1, r.pa, r.rx};
		repeat (3) @(posedge clk);
		#2;
		check(outs, model(r));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Watchdog: a full run needs about 12k clocks
	initial begin
		#(40 * 40000);
		miscompares++;
		tally_and_finish();
	end
	// Rows first; the leading pin-only rows leave the serial port idle
	initial begin
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].tk !== cur_tk)
				host.wr(`LROVR_SLAVE_ADDR, `LROVR_ADDR_TAKEOVER, rows[i].tk);
			if (rows[i].ctrl !== cur_ctrl)
				host.wr(`LROVR_SLAVE_ADDR, `LROVR_ADDR_ROUTE_CTRL, rows[i].ctrl);
			{cur_tk, cur_ctrl} = {rows[i].tk, rows[i].ctrl};
			settle(rows[i]);
			$display("row %0d done", i);
		end
		// Mid-run reset clears the takeover and quiets all outputs
		rst_n = 1'b0;
		#2 check(outs, 11'h000);
		repeat (2) @(posedge clk);
		#2 rst_n = 1'b1;
		settle('{8'h00, 8'h00, 2, 1, 3, 0});
		foreach (tbl[i]) begin
			host.rd(tbl[i][15:8], v);
			check({host.ack_ok, v}, {1'b1, tbl[i][7:0]});
		end
		$display("reset and table done");
		// Read-only, reserved and masked bits; ID must not move
		host.wr(`LROVR_SLAVE_ADDR, 8'h51, 8'hFF);
		host.wr(`LROVR_SLAVE_ADDR, 8'h56, 8'hA5);
		host.wr(`LROVR_SLAVE_ADDR, 8'h5E, 8'hFF);
		host.wr(`LROVR_SLAVE_ADDR, 8'h5F, 8'hFF);
		host.rd(8'h51, v);
		check(v, tbl[1][7:0]);
		host.rd(8'h56, v);
		check(v, 8'hA5);
		host.rd(8'h5E, v);
		check(v, 8'h07);
		host.rd(8'h5F, v);
		check(v, 8'hFC);
		settle('{8'h07, 8'hFC, 0, 0, 2, 0});
		// Foreign address gets no acknowledge and changes nothing
		host.wr(`LROVR_SLAVE_ADDR ^ 7'h01, `LROVR_ADDR_TAKEOVER, 8'h00);
		check(host.ack_ok, 1'b0);
		settle('{8'h07, 8'hFC, 3, 1, 0, 4'hF});
		$display("access tests done");
		tally_and_finish();
	end
endmodule // tb_lane_route_override_regs
